// >>> icct_pkg.sv
package icct_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CAPCTL0  = 8'h04;
    localparam logic [7:0] OFS_CAPCTL1  = 8'h08;
    localparam logic [7:0] OFS_FRT      = 8'h0C;
    localparam logic [7:0] OFS_CAP0     = 8'h10;
    localparam logic [7:0] OFS_CMP0     = 8'h28;
    localparam logic [7:0] OFS_CMP1     = 8'h2C;
    localparam logic [7:0] OFS_MUX      = 8'h30;
    localparam logic [7:0] OFS_STEP     = 8'h04;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ACTIVE  = 0;
    localparam int CTRL_TB_LSB  = 4;
    localparam int CTRL_TB_W    = 3;
    localparam int CTRL_EN0     = 8;
    localparam int CTRL_EN1     = 9;
    localparam int CTRL_SET1    = 16;
    localparam int CTRL_SET0    = 17;
    localparam int CTRL_CLR1    = 24;
    localparam int CTRL_CLR0    = 25;

    // ------------------------------------------------------------
    // capture control: one byte per channel, four channels per word
    // ------------------------------------------------------------
    localparam int CAP_FIELD_W  = 8;
    localparam int CAP_PER_REG  = 4;
    localparam int CAP_EDGE_LSB = 0;
    localparam int CAP_BYP_BIT  = 2;
    localparam int MUX_FIELD_W  = 4;

    // edge selection codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_OFF  = 2'h3;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [1:0]  RST_EDGE     = EDGE_OFF;
    localparam logic [1:0]  FILT_STABLE  = 2'h3;
    localparam int          DIV_W        = 7;
endpackage

// >>> icct_timer.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE1: one free-running 32-bit up counter is the shared time reference.
// RULE2: counter wrap from all ones to zero pulses the overflow event.
// RULE3: time base is block clock divided by two to the select code.
// RULE4: capture register loads the counter on the programmed input edge.
// RULE5: capture registers are read-only, overwritten on every edge.
// RULE6: each capture load pulses that channel's capture event.
// RULE7: any trigger input can be routed to any of six channels.
// RULE8: filter output changes only after three steady filter ticks.
// RULE9: each channel may bypass its filter on its own.
// RULE10: pulses must last long enough relative to the filter tick.
// RULE11: two 32-bit compare registers, each with its own enable bit.
// RULE12: enabled compare equal to counter pulses that channel's compare event.
// RULE13: each match toggles that channel's compare output flip-flop.
// RULE14: software can set or clear each compare output independently.
// RULE15: software should disable a compare before altering it or counter.
// RULE16: block reports inactive when not activated or when sleep asserted.
// RULE17: after sleep the counter resumes from its held value.
// RULE18: reset returns every register and all logic to defaults.
// RULE19: time base select lives in control bits 6 to 4.
// RULE20: writing one to a set bit drives output high; reads show output.
// RULE21: compare enables sit at control bits 8 and 9, one enables.
// RULE22: each channel selects rising, falling, both edges or none.
module icct_timer #(
    parameter int N_INPUTS = 16,
    parameter int N_CAP    = 6
) (
    input  wire  logic                pclk,                   // block clock
    input  wire  logic                presetn,                // async reset, low
    input  wire  logic                psel,                   // apb select
    input  wire  logic                penable,                // apb enable
    input  wire  logic                pwrite,                 // apb direction
    input  wire  logic [7:0]          paddr,                  // apb byte address
    input  wire  logic [31:0]         pwdata,                 // apb write data
    output logic       [31:0]         prdata,                 // apb read data
    output logic                      pready,                 // apb ready
    output logic                      pslverr,                // apb error
    input  wire  logic [N_INPUTS-1:0] capture_trigger_input,  // trigger pins
    input  wire  logic                filter_tick_clock,      // filter tick pulse
    input  wire  logic                sleep_enable,           // sleep request
    output logic                      block_inactive,         // low power ok
    output logic                      compare_out_0,          // compare pin 0
    output logic                      compare_out_1,          // compare pin 1
    output logic                      overflow_event,         // wrap pulse
    output logic       [N_CAP-1:0]    capture_event,          // capture pulses
    output logic       [1:0]          compare_event           // match pulses
);
    localparam int SEL_W = icct_pkg::MUX_FIELD_W;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    if (N_INPUTS < 1 || N_INPUTS > (1 << SEL_W) || N_CAP != 6) begin : g_bad_size
        $error("icct_timer: unsupported N_INPUTS or N_CAP");
    end

    // ------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------
    logic        wr_stb;
    logic        rd_cyc;
    logic [31:0] rd_mux;
    logic        rd_bad;
    logic        active;
    logic [2:0]  tb_sel;
    logic [1:0]  cmp_en;
    logic [31:0] frt;
    logic [31:0] cmp_val [2];
    logic [31:0] cap_val [N_CAP];
    logic [1:0]  edge_sel [N_CAP];
    logic [N_CAP-1:0] bypass;
    logic [SEL_W-1:0] mux_sel [N_CAP];
    logic [1:0]  cmp_q;
    assign rd_cyc = psel & penable & ~pready;
    assign wr_stb = psel & penable & pready & pwrite;

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_stb && (paddr == ofs);
    endfunction

    always_comb begin
        rd_mux = icct_pkg::RST_WORD;
        rd_bad = 1'b0;
        case (paddr)
            icct_pkg::OFS_CTRL: begin
                rd_mux[icct_pkg::CTRL_ACTIVE] = active;
                rd_mux[icct_pkg::CTRL_TB_LSB +: icct_pkg::CTRL_TB_W] = tb_sel;
                rd_mux[icct_pkg::CTRL_EN0] = cmp_en[0];
                rd_mux[icct_pkg::CTRL_EN1] = cmp_en[1];
                rd_mux[icct_pkg::CTRL_SET0] = cmp_q[0];  // see RULE20
                rd_mux[icct_pkg::CTRL_SET1] = cmp_q[1];
                rd_mux[icct_pkg::CTRL_CLR0] = cmp_q[0];
                rd_mux[icct_pkg::CTRL_CLR1] = cmp_q[1];
            end
            icct_pkg::OFS_CAPCTL0, icct_pkg::OFS_CAPCTL1: begin
                for (int i = 0; i < N_CAP; i++) begin
                    if ((i / icct_pkg::CAP_PER_REG) == int'(paddr[3])) begin
                        rd_mux[(i % icct_pkg::CAP_PER_REG) * icct_pkg::CAP_FIELD_W
                               + icct_pkg::CAP_EDGE_LSB +: 2] = edge_sel[i];
                        rd_mux[(i % icct_pkg::CAP_PER_REG) * icct_pkg::CAP_FIELD_W
                               + icct_pkg::CAP_BYP_BIT] = bypass[i];
                    end
                end
            end
            icct_pkg::OFS_FRT:  rd_mux = frt;
            icct_pkg::OFS_CMP0: rd_mux = cmp_val[0];
            icct_pkg::OFS_CMP1: rd_mux = cmp_val[1];
            icct_pkg::OFS_MUX: begin
                for (int i = 0; i < N_CAP; i++) begin
                    rd_mux[i * SEL_W +: SEL_W] = mux_sel[i];
                end
            end
            default: begin
                rd_bad = 1'b1;
                for (int i = 0; i < N_CAP; i++) begin
                    if (paddr == 8'(icct_pkg::OFS_CAP0 + i * icct_pkg::OFS_STEP)) begin
                        rd_mux = cap_val[i];  // see RULE5
                        rd_bad = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= icct_pkg::RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_cyc;
            pslverr <= rd_cyc & (rd_bad | (pwrite & paddr >= icct_pkg::OFS_CAP0
                       & paddr < icct_pkg::OFS_CMP0));  // see RULE5
            if (rd_cyc && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin  // see RULE18
            active <= 1'b0;
            tb_sel <= 3'h0;
            cmp_en <= 2'h0;
            cmp_val[0] <= icct_pkg::RST_WORD;
            cmp_val[1] <= icct_pkg::RST_WORD;
        end else begin
            if (wr_hit(icct_pkg::OFS_CTRL)) begin
                active <= pwdata[icct_pkg::CTRL_ACTIVE];
                tb_sel <= pwdata[icct_pkg::CTRL_TB_LSB +: icct_pkg::CTRL_TB_W];  // see RULE19
                cmp_en <= {pwdata[icct_pkg::CTRL_EN1], pwdata[icct_pkg::CTRL_EN0]};  // see RULE21
            end
            if (wr_hit(icct_pkg::OFS_CMP0)) begin
                cmp_val[0] <= pwdata;  // see RULE11
            end
            if (wr_hit(icct_pkg::OFS_CMP1)) begin
                cmp_val[1] <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // time base and free-running counter
    // ------------------------------------------------------------
    logic [icct_pkg::DIV_W-1:0] div_cnt;
    logic [icct_pkg::DIV_W-1:0] div_mask;
    logic                       run;
    logic                       frt_tick;
    logic                       frt_wr;

    // counting halts, not clears, while asleep, so it resumes where it stopped
    assign run      = active & ~sleep_enable;  // see RULE17
    assign frt_wr   = wr_hit(icct_pkg::OFS_FRT);
    assign div_mask = ~({icct_pkg::DIV_W{1'b1}} << tb_sel);
    assign frt_tick = run & ((div_cnt & div_mask) == div_mask);  // see RULE3

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt        <= '0;
            frt            <= icct_pkg::RST_WORD;
            overflow_event <= 1'b0;
            block_inactive <= 1'b1;
        end else begin
            block_inactive <= ~active | sleep_enable;  // see RULE16
            if (run) begin
                div_cnt <= div_cnt + 1'b1;
            end
            overflow_event <= 1'b0;
            if (frt_wr) begin
                frt <= pwdata;
            end else if (frt_tick) begin
                frt <= frt + 32'h0000_0001;  // see RULE1
                overflow_event <= (frt == 32'hFFFF_FFFF);  // see RULE2
            end
        end
    end

    // ------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------
    logic [1:0] eq_now;
    logic [1:0] eq_prev;
    logic [1:0] hit;
    logic [1:0] sw_set;
    logic [1:0] sw_clr;

    assign sw_set = {2{wr_hit(icct_pkg::OFS_CTRL)}}
                    & {pwdata[icct_pkg::CTRL_SET1], pwdata[icct_pkg::CTRL_SET0]};
    // clear is ignored when the same channel is set in the same write
    assign sw_clr = {2{wr_hit(icct_pkg::OFS_CTRL)}} & ~sw_set
                    & {pwdata[icct_pkg::CTRL_CLR1], pwdata[icct_pkg::CTRL_CLR0]};

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_cmp
            // edge of equality so a slow time base fires once per count value
            assign eq_now[c] = cmp_en[c] & (cmp_val[c] == frt);
            assign hit[c]    = eq_now[c] & ~eq_prev[c];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    eq_prev[c]       <= 1'b0;
                    compare_event[c] <= 1'b0;
                    cmp_q[c]         <= 1'b0;
                end else begin
                    eq_prev[c]       <= eq_now[c];
                    compare_event[c] <= hit[c];  // see RULE12
                    if (sw_set[c]) begin
                        cmp_q[c] <= 1'b1;  // see RULE14
                    end else if (sw_clr[c]) begin
                        cmp_q[c] <= 1'b0;
                    end else if (hit[c]) begin
                        cmp_q[c] <= ~cmp_q[c];  // see RULE13
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out_0 <= 1'b0;
            compare_out_1 <= 1'b0;
        end else begin
            compare_out_0 <= cmp_q[0];
            compare_out_1 <= cmp_q[1];
        end
    end

    // ------------------------------------------------------------
    // capture channels
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] mode, input logic was, input logic now);
        case (mode)
            icct_pkg::EDGE_RISE: edge_hit = ~was & now;
            icct_pkg::EDGE_FALL: edge_hit = was & ~now;
            icct_pkg::EDGE_BOTH: edge_hit = was ^ now;
            default:             edge_hit = 1'b0;
        endcase
    endfunction

    logic [N_CAP-1:0] raw_in;
    logic [N_CAP-1:0] filt;
    logic [N_CAP-1:0] chan_in;
    logic [N_CAP-1:0] chan_prev;
    logic [N_CAP-1:0] cap_hit;
    logic [1:0]       filt_cnt [N_CAP];

    generate
        for (c = 0; c < N_CAP; c++) begin : g_cap
            localparam int FB = (c % icct_pkg::CAP_PER_REG) * icct_pkg::CAP_FIELD_W;
            localparam logic [7:0] CFG_OFS = (c < icct_pkg::CAP_PER_REG)
                                             ? icct_pkg::OFS_CAPCTL0 : icct_pkg::OFS_CAPCTL1;
            assign raw_in[c]  = capture_trigger_input[mux_sel[c]];  // see RULE7
            assign chan_in[c] = bypass[c] ? raw_in[c] : filt[c];  // see RULE9
            assign cap_hit[c] = edge_hit(edge_sel[c], chan_prev[c], chan_in[c]);  // see RULE22
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    edge_sel[c] <= icct_pkg::RST_EDGE;
                    bypass[c]   <= 1'b0;
                    mux_sel[c]  <= '0;
                end else begin
                    if (wr_hit(CFG_OFS)) begin
                        edge_sel[c] <= pwdata[FB + icct_pkg::CAP_EDGE_LSB +: 2];
                        bypass[c]   <= pwdata[FB + icct_pkg::CAP_BYP_BIT];
                    end
                    if (wr_hit(icct_pkg::OFS_MUX)
                        && int'(pwdata[c * SEL_W +: SEL_W]) < N_INPUTS) begin
                        mux_sel[c] <= pwdata[c * SEL_W +: SEL_W];
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt[c]     <= 1'b0;
                    filt_cnt[c] <= 2'h0;
                end else if (filter_tick_clock) begin
                    if (raw_in[c] == filt[c]) begin
                        filt_cnt[c] <= 2'h0;
                    end else if (filt_cnt[c] == icct_pkg::FILT_STABLE - 2'h1) begin
                        filt[c]     <= raw_in[c];  // see RULE8
                        filt_cnt[c] <= 2'h0;
                    end else begin
                        filt_cnt[c] <= filt_cnt[c] + 2'h1;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    chan_prev[c]     <= 1'b0;
                    cap_val[c]       <= icct_pkg::RST_WORD;
                    capture_event[c] <= 1'b0;
                end else begin
                    chan_prev[c]     <= chan_in[c];
                    capture_event[c] <= cap_hit[c];  // see RULE6
                    if (cap_hit[c]) begin
                        cap_val[c] <= frt;  // see RULE4
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_overflow;
        (frt_tick && frt == 32'hFFFF_FFFF && !frt_wr)
        |=> overflow_event && frt == 32'h0;
    endproperty
    a_overflow: assert property (p_overflow) else $error("no overflow pulse"); // see RULE2
    property p_count;
        (frt_tick && !frt_wr) |=> frt == $past(frt) + 32'h1;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step"); // see RULE1
    property p_div;
        (run && tb_sel == 3'h1 && frt_tick) |=> !frt_tick;
    endproperty
    a_div: assert property (p_div) else $error("divide by two broken"); // see RULE3
    property p_hold;
        (sleep_enable && !frt_wr) |=> frt == $past(frt);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved in sleep"); // see RULE17
    property p_capture;
        cap_hit[0] |=> capture_event[0] && cap_val[0] == $past(frt);
    endproperty
    a_capture: assert property (p_capture) else $error("capture 0 missed"); // see RULE4
    property p_compare;
        (cmp_en[0] && cmp_val[0] == frt && !eq_prev[0])
        |=> compare_event[0] ##1 !compare_event[0] || eq_now[0] == 1'b0;
    endproperty
    a_compare: assert property (p_compare) else $error("compare 0 event wrong"); // see RULE12
    property p_toggle;
        (hit[1] && !sw_set[1] && !sw_clr[1]) |=> ##1 compare_out_1 != $past(compare_out_1, 1);
    endproperty
    a_toggle: assert property (p_toggle) else $error("compare 1 did not toggle"); // see RULE13
    property p_set;
        sw_set[0] |=> ##1 compare_out_0;
    endproperty
    a_set: assert property (p_set) else $error("set did not raise output"); // see RULE14
    property p_inactive;
        (!active || sleep_enable) |=> block_inactive;
    endproperty
    a_inactive: assert property (p_inactive) else $error("inactive not reported"); // see RULE16
endmodule

// >>> icct_far_end.sv
`timescale 1ns/1ps
module icct_far_end (
    input  wire logic   pclk,  // block clock
    output logic [15:0] trig,  // trigger pins
    output logic        tick   // filter tick pulse
);
    initial trig = 16'h0000;
    initial tick = 1'b0;
    // a tick every second cycle makes the filter delay visible at all
    always @(posedge pclk) begin
        tick <= ~tick;
    end
    // a level lasts len cycles, which covers len/2 ticks
    task automatic pulse(input int idx, input int len);
        @(posedge pclk);
        trig[idx] <= 1'b1;
        repeat (len) @(posedge pclk);
        trig[idx] <= 1'b0;
        repeat (len) @(posedge pclk);
    endtask
endmodule

// >>> input_capture_compare_timer_tb.sv
`timescale 1ns/1ps
module input_capture_compare_timer_tb;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, sleep_enable;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, a;
    logic        pready, pslverr, err, block_inactive, overflow_event;
    logic        compare_out_0, compare_out_1;
    logic [15:0] trig;
    logic        tick;
    logic [5:0]  capture_event;
    logic [1:0]  compare_event;
    logic [1:0]  edges [4];
    int          expn [4] = '{1, 1, 2, 0};
    int          fails = 0, compares = 0, cycles = 0, ncap0 = 0, ncap1 = 0;

    icct_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_trigger_input(trig), .filter_tick_clock(tick),
        .sleep_enable(sleep_enable), .block_inactive(block_inactive),
        .compare_out_0(compare_out_0), .compare_out_1(compare_out_1),
        .overflow_event(overflow_event), .capture_event(capture_event),
        .compare_event(compare_event));
    icct_far_end u_far (.pclk(pclk), .trig(trig), .tick(tick));

    always #20 pclk = ~pclk;
    // event pulses stand one cycle, so they are counted where they occur
    always @(posedge pclk) begin
        ncap0 += int'(capture_event[0] === 1'b1);
        ncap1 += int'(capture_event[1] === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    task finish_test;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= wd; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_reset;
        apb(1'b0, icct_pkg::OFS_CTRL, 32'h0);
        chk(rd, icct_pkg::RST_WORD);
        chk(32'(block_inactive), 32'h1);
        apb(1'b0, icct_pkg::OFS_CAPCTL0, 32'h0);
        chk(rd, 32'h0303_0303);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
    endtask

    task t_overflow;
        int n;
        n = 0;
        apb(1'b1, icct_pkg::OFS_FRT, 32'hFFFF_FFF0);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h1);
        while (overflow_event !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(overflow_event), 32'h1);
        chk(32'(block_inactive), 32'h0);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        chk(32'(rd < 32'h40), 32'h1);
    endtask

    task t_timebase;
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h31);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        a = rd;
        repeat (80) @(posedge pclk);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        // 84 cycles between samples at a divide of 8
        chk(32'(rd - a >= 32'd9 && rd - a <= 32'd11), 32'h1);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h11);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        a = rd;
        repeat (40) @(posedge pclk);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        // 44 cycles between samples at a divide of 2
        chk(rd - a, 32'd22);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h1);
    endtask

    task t_sleep;
        sleep_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(block_inactive), 32'h1);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        a = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        chk(rd, a);
        sleep_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(block_inactive), 32'h0);
        apb(1'b0, icct_pkg::OFS_FRT, 32'h0);
        chk(32'(rd > a && rd < a + 32'd40), 32'h1);
    endtask

    task t_compare;
        int n;
        n = 0;
        apb(1'b1, icct_pkg::OFS_FRT, 32'h0);
        apb(1'b1, icct_pkg::OFS_CMP0, 32'd60);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h101);
        while (compare_event[0] !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(compare_event), 32'h1);
        repeat (3) @(posedge pclk);
        chk({compare_out_1, compare_out_0}, 32'h1);
        apb(1'b0, icct_pkg::OFS_CTRL, 32'h0);
        chk(32'(rd[17]), 32'h1);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h1);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h0200_0001);
        repeat (3) @(posedge pclk);
        chk(32'(compare_out_0), 32'h0);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h0001_0001);
        repeat (3) @(posedge pclk);
        chk({compare_out_1, compare_out_0}, 32'h2);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h0102_0001);
        repeat (3) @(posedge pclk);
        chk({compare_out_1, compare_out_0}, 32'h1);
        apb(1'b1, icct_pkg::OFS_FRT, 32'h0);
        apb(1'b1, icct_pkg::OFS_CMP1, 32'd40);
        apb(1'b1, icct_pkg::OFS_CTRL, 32'h201);
        n = 0;
        while (compare_event[1] !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(compare_event), 32'h2);
        repeat (3) @(posedge pclk);
        chk({compare_out_1, compare_out_0}, 32'h3);
    endtask

    task t_capture;
        int base;
        apb(1'b1, icct_pkg::OFS_MUX, 32'h53);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, icct_pkg::OFS_CAPCTL0, 32'h0303_0104 | 32'(edges[i]));
            base = ncap0;
            u_far.pulse(3, 8);
            chk(32'(ncap0 - base), 32'(expn[i]));
            apb(1'b0, icct_pkg::OFS_CAP0, 32'h0);
            if (i == 0) a = rd;
        end
        chk(32'(rd > a), 32'h1);
        a = rd;
        apb(1'b1, icct_pkg::OFS_CAP0, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, icct_pkg::OFS_CAP0, 32'h0);
        chk(rd, a);
        // channel 0 listens on both edges, so a stray route to pin 5 would show
        apb(1'b1, icct_pkg::OFS_CAPCTL0, 32'h0303_0106);
        base = ncap0;
        // a two-cycle pulse spans one tick only, too short for the filter
        u_far.pulse(5, 2);
        chk(32'(ncap1), 32'h0);
        u_far.pulse(5, 16);
        chk(32'(ncap1), 32'h1);
        chk(32'(ncap0 - base), 32'h0);
    endtask

    initial begin
        edges = '{icct_pkg::EDGE_RISE, icct_pkg::EDGE_FALL, icct_pkg::EDGE_BOTH,
                  icct_pkg::EDGE_OFF};
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; sleep_enable = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_overflow();
        t_timebase();
        t_sleep();
        t_compare();
        t_capture();
        finish_test();
    end
endmodule
